/* rtl/ocp_pkg.sv */
// Summary of operation
// [RL1] Directional component is current times cos(displacement-reference)
// [RL2] Directional pick-up when component reaches level
// [RL3] Directional mode needs no voltage threshold
// [RL4] User picks reference angle per application
// [RL5] Restraint scales level by smallest phase voltage
// [RL6] Restraint voltage is min(E*sqrt3)/rated voltage
// [RL7] Ratio (0.8/0.6)(u-0.8)+1, clamped 0.2..1
// [RL8] Blocking logic mode is selectable per function
// [RL9] Instantaneous element: set above level, reset 95%
// [RL10] Instantaneous state routed to chosen output relay
// [RL11] Blocking output forced off after release time
// [RL12] Active blocking input inhibits delayed trip
// [RL13] Release off: block while input stays active
// [RL14] Doubled option: input ignored after twice release
// [RL15] Inrush to 1.5 In within 60 ms doubles level
// [RL16] Doubling ends below 1.25 In or max time
// [RL17] Trip after level held for trip delay
// [RL18] Supervision: voltage, largest current, within 90 degrees
// [RL19] Disabled function neither operates nor trips
// [RL20] Setting selects recorder trigger on trip
// [RL21] Directional pick-up when any phase qualifies
// [RL22] Inrush window starts at first measurable current
package ocp_pkg;

	// ****************************************
	// Time base
	// ****************************************
	localparam int CLK_HZ = 10000000;
	localparam int TICK_US = 1000;
	localparam int TICK_CYCLES = CLK_HZ / 1000000 * TICK_US;
	localparam int INRUSH_WINDOW_MS = 60;

	// ****************************************
	// Fixed-point scales (current: 1000 counts = 1.0 In)
	// ****************************************
	localparam logic [15:0] IN_UNIT = 16'h03e8;
	localparam logic [15:0] INRUSH_HI = 16'h05dc; // 1.5 In
	localparam logic [15:0] INRUSH_LO = 16'h04e2; // 1.25 In
	localparam logic [15:0] MIN_MEAS = 16'h0014; // 0.02 In
	localparam logic [7:0] RESET_PCT = 8'h5f; // 95 percent
	localparam logic [7:0] PCT_DIV = 8'h64;
	localparam int TRIG_FRAC = 14; // Q14 cosine and sine
	localparam int RATIO_FRAC = 12; // Q12 ratio and voltage
	localparam logic [15:0] SQRT3_Q12 = 16'h1bb6;
	localparam logic [15:0] RATIO_ONE = 16'h1000;
	localparam logic [15:0] U_LO = 16'h0333; // 0.2
	localparam logic [15:0] U_HI = 16'h0ccd; // 0.8
	localparam logic [15:0] V_PRESENT = 16'h0029; // 1 percent
	localparam int DIV_STEPS = 30;

	// ****************************************
	// Modes and carriers
	// ****************************************
	typedef enum logic [1:0] {
		MODE_NONDIR = 2'h0,
		MODE_SUPERV = 2'h1,
		MODE_DIRECT = 2'h2
	} dir_mode_e;

	typedef struct packed {
		logic [15:0] mag;
		logic signed [15:0] re;
		logic signed [15:0] im;
	} phase_meas_s;

	typedef struct packed {
		logic enable;
		dir_mode_e mode;
		logic restraint_en;
		logic inrush_doubling_enable;
		logic block_logic_en;
		logic block_input_release_option;
		logic recorder_trigger_enable;
		logic [15:0] pickup_level;
		logic signed [15:0] cos_ref;
		logic signed [15:0] sin_ref;
		logic [17:0] trip_delay;
		logic [17:0] block_output_release_time;
		logic [17:0] doubling_max_time;
		logic [15:0] rated_voltage;
	} settings_s;

endpackage

/* rtl/restraint_calc.sv */
`timescale 1ns/10ps
module restraint_calc (
	// Clock and reset
	input wire logic clock,
	input wire logic resetn,
	// Settings and voltages
	input wire logic restraint_en,
	input wire logic [15:0] pickup_level,
	input wire logic [15:0] rated_voltage,
	input wire logic [2:0][15:0] phase_neutral_voltage,
	// Results
	output logic [15:0] eff_level,
	output logic [15:0] volt_norm
);

	typedef enum logic [0:0] {
		DV_LOAD = 1'h0,
		DV_RUN = 1'h1
	} div_state_e;

	div_state_e st_ff, nxt_st;
	logic [30:0] rem_ff, nxt_rem;
	logic [29:0] quo_ff, nxt_quo;
	logic [4:0] cnt_ff, nxt_cnt;
	logic [15:0] eff_ff, nxt_eff;
	logic [15:0] u_ff, nxt_u;
	logic [15:0] ratio_ff, nxt_ratio;
	logic [15:0] emin;
	logic [30:0] trial;
	logic [15:0] u_q;
	logic signed [19:0] lin;
	logic [31:0] prod;

	// ****************************************
	// Serial divider for normalised voltage
	// ****************************************
	// Smallest phase voltage, scaled by sqrt3, over the rated setting
	always_comb begin
		emin = phase_neutral_voltage[0];
		if (phase_neutral_voltage[1] < emin) emin = phase_neutral_voltage[1]; // RL6
		if (phase_neutral_voltage[2] < emin) emin = phase_neutral_voltage[2];
		trial = {rem_ff[29:0], quo_ff[29]};
		nxt_st = st_ff;
		nxt_rem = rem_ff;
		nxt_quo = quo_ff;
		nxt_cnt = cnt_ff;
		nxt_u = u_ff;
		unique case (st_ff)
			DV_LOAD: begin
				nxt_rem = '0;
				nxt_quo = 30'(emin * ocp_pkg::SQRT3_Q12); // RL6
				nxt_cnt = '0;
				nxt_st = DV_RUN;
			end
			DV_RUN: begin
				if (trial >= {15'h0000, rated_voltage}) begin
					nxt_rem = trial - {15'h0000, rated_voltage};
					nxt_quo = {quo_ff[28:0], 1'b1};
				end else begin
					nxt_rem = trial;
					nxt_quo = {quo_ff[28:0], 1'b0};
				end
				nxt_cnt = cnt_ff + 5'h01;
				if (cnt_ff == 5'(ocp_pkg::DIV_STEPS - 1)) begin
					nxt_st = DV_LOAD;
					nxt_u = (|nxt_quo[29:16]) ? 16'hffff : nxt_quo[15:0];
				end
			end
		endcase
	end

	// Ratio from the normalised voltage, clamped at both ends
	always_comb begin
		u_q = (rated_voltage == 16'h0000) ? ocp_pkg::U_HI : u_ff;
		// Signed throughout: below 0.8 the offset is negative
		lin = (($signed(20'(u_q)) - $signed(20'(ocp_pkg::U_HI))) * 20'sh00004) / 20'sh00003;
		if (u_q <= ocp_pkg::U_LO)
			nxt_ratio = ocp_pkg::U_LO; // RL7
		else if (u_q >= ocp_pkg::U_HI)
			nxt_ratio = ocp_pkg::RATIO_ONE; // RL7
		else
			nxt_ratio = 16'(lin + 20'(ocp_pkg::RATIO_ONE)); // RL7
		prod = pickup_level * ratio_ff;
		nxt_eff = restraint_en ? prod[27:12] : pickup_level; // RL5
	end

	// Registers of the restraint path
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			st_ff <= DV_LOAD;
			rem_ff <= '0;
			quo_ff <= '0;
			cnt_ff <= '0;
			u_ff <= 16'hffff;
			ratio_ff <= ocp_pkg::RATIO_ONE;
			// Top level until the first update, so a zero projection cannot pick up
			eff_ff <= 16'hffff;
		end else begin
			st_ff <= nxt_st;
			rem_ff <= nxt_rem;
			quo_ff <= nxt_quo;
			cnt_ff <= nxt_cnt;
			u_ff <= nxt_u;
			ratio_ff <= nxt_ratio;
			eff_ff <= nxt_eff;
		end
	end

	assign eff_level = eff_ff;
	assign volt_norm = u_ff;

	default clocking @(posedge clock); endclocking
	default disable iff (!resetn);

	property p_ratio_range;
		(ratio_ff >= ocp_pkg::U_LO) && (ratio_ff <= ocp_pkg::RATIO_ONE);
	endproperty
	a_ratio_range: assert property (p_ratio_range) else $error("ratio out of range"); // RL7

	property p_restraint_off;
		!restraint_en |=> eff_level == $past(pickup_level);
	endproperty
	a_restraint_off: assert property (p_restraint_off) else $error("unrestrained level"); // RL5

endmodule

/* rtl/ocp_element.sv */
`timescale 1ns/10ps
module ocp_element #(
	parameter int TICK_CYCLES = ocp_pkg::TICK_CYCLES,
	parameter int RELAYS = 4
) (
	// Clock and reset
	input wire logic clock,
	input wire logic resetn,
	// Settings
	input wire ocp_pkg::settings_s cfg,
	input wire logic [1:0] relay_select,
	// Measurements
	input wire ocp_pkg::phase_meas_s [2:0] phase_current,
	input wire logic [2:0][15:0] phase_neutral_voltage,
	// Digital input contact
	input wire logic blocking_input,
	// Outputs
	output logic trip,
	output logic instantaneous,
	output logic [RELAYS-1:0] blocking_output,
	output logic recorder_trigger,
	output logic doubling_active
);

	typedef enum logic [1:0] {
		IR_IDLE = 2'h0,
		IR_WINDOW = 2'h1,
		IR_DOUBLE = 2'h2,
		IR_SPENT = 2'h3
	} inrush_state_e;

	logic in_meta_ff, in_sync_ff;
	logic dbl_now;
	logic [13:0] div_ff, nxt_div;
	logic tick;
	logic [15:0] base_lvl, volt_norm;
	logic [16:0] lvl, rst_lvl;
	logic [2:0] gt_mag, ge_mag_rst, ge_idx, ge_idx_rst, dir_pos;
	logic [1:0] big;
	logic volt_ok, op, hold;
	logic inst_ff, nxt_inst;
	logic [17:0] delay_ff, nxt_delay, post_ff, nxt_post;
	logic expired, out_released, in_ignored, blocked;
	logic trip_ff, nxt_trip, rec_ff, nxt_rec;
	logic [RELAYS-1:0] blk_out_ff, nxt_blk_out;
	inrush_state_e ir_ff, nxt_ir;
	logic [17:0] ir_cnt_ff, nxt_ir_cnt;
	logic [15:0] imax;

	// ****************************************
	// Input synchroniser and millisecond tick
	// ****************************************
	// Contact input is asynchronous to the clock
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			in_meta_ff <= 1'b0;
			in_sync_ff <= 1'b0;
		end else begin
			in_meta_ff <= blocking_input;
			in_sync_ff <= in_meta_ff;
		end
	end

	// Divider gives a one-cycle enable per millisecond
	always_comb begin
		tick = (div_ff == 14'(TICK_CYCLES - 1));
		nxt_div = tick ? 14'h0000 : div_ff + 14'h0001;
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) div_ff <= '0;
		else div_ff <= nxt_div;
	end

	// ****************************************
	// Pick-up level: restraint and doubling
	// ****************************************
	restraint_calc u_restraint (
		.clock(clock),
		.resetn(resetn),
		.restraint_en(cfg.restraint_en),
		.pickup_level(cfg.pickup_level),
		.rated_voltage(cfg.rated_voltage),
		.phase_neutral_voltage(phase_neutral_voltage),
		.eff_level(base_lvl),
		.volt_norm(volt_norm)
	);

	// Doubled level during inrush; reset level sits at 95 percent
	// Doubling acts in the cycle it is detected, so an inrush edge during IR_WINDOW cannot pick up
	always_comb begin
		dbl_now = (nxt_ir == IR_DOUBLE);
		lvl = dbl_now ? {base_lvl, 1'b0} : {1'b0, base_lvl}; // RL15
		rst_lvl = 17'((25'(lvl) * 25'(ocp_pkg::RESET_PCT)) / 25'(ocp_pkg::PCT_DIV)); // RL9
	end

	// ****************************************
	// Per-phase comparisons
	// ****************************************
	for (genvar p = 0; p < 3; p++) begin : g_phase
		logic signed [32:0] acc;
		logic signed [18:0] idx;
		// Projection on the reference: re*cos(a) + im*sin(a) = I*cos(phi-a)
		always_comb begin
			acc = 33'(phase_current[p].re * cfg.cos_ref) + 33'(phase_current[p].im * cfg.sin_ref); // RL1
			idx = 19'(acc >>> ocp_pkg::TRIG_FRAC);
		end
		assign gt_mag[p] = {1'b0, phase_current[p].mag} > lvl;
		assign ge_mag_rst[p] = {1'b0, phase_current[p].mag} >= rst_lvl;
		assign ge_idx[p] = idx >= $signed({2'b00, lvl}); // RL2
		assign ge_idx_rst[p] = idx >= $signed({2'b00, rst_lvl});
		assign dir_pos[p] = idx > 19'sh00000; // RL18
	end

	// Largest phase current and voltage presence
	always_comb begin
		big = 2'h0;
		if (phase_current[1].mag > phase_current[big].mag) big = 2'h1;
		if (phase_current[2].mag > phase_current[big].mag) big = 2'h2;
		imax = phase_current[big].mag;
		volt_ok = volt_norm >= ocp_pkg::V_PRESENT; // RL18
	end

	// ****************************************
	// Instantaneous element
	// ****************************************
	// Operate and hold conditions per directional mode
	always_comb begin
		op = 1'b0;
		hold = 1'b0;
		unique case (cfg.mode)
			ocp_pkg::MODE_NONDIR: begin
				op = |gt_mag;
				hold = |ge_mag_rst;
			end
			ocp_pkg::MODE_SUPERV: begin
				op = volt_ok && gt_mag[big] && dir_pos[big]; // RL18
				hold = volt_ok && ge_mag_rst[big] && dir_pos[big];
			end
			ocp_pkg::MODE_DIRECT: begin
				// No voltage gate, so it works on a nearly collapsed voltage
				op = |ge_idx; // RL21 RL3
				hold = |ge_idx_rst;
			end
			default: begin
				op = 1'b0;
				hold = 1'b0;
			end
		endcase
		nxt_inst = cfg.enable && (inst_ff ? hold : op); // RL9 RL19
	end

	// ****************************************
	// Delay, release and trip
	// ****************************************
	// Counters run on the tick and saturate rather than wrap
	always_comb begin
		expired = inst_ff && (delay_ff >= cfg.trip_delay); // RL17
		nxt_delay = delay_ff;
		nxt_post = post_ff;
		if (!inst_ff) begin
			nxt_delay = '0;
			nxt_post = '0;
		end else if (tick) begin
			if (!expired) nxt_delay = delay_ff + 18'h00001;
			else if (post_ff != 18'h3ffff) nxt_post = post_ff + 18'h00001;
		end
		out_released = expired && (post_ff >= cfg.block_output_release_time); // RL11
		in_ignored = cfg.block_input_release_option && expired &&
			({1'b0, post_ff} >= {cfg.block_output_release_time, 1'b0}); // RL14
		blocked = cfg.block_logic_en && in_sync_ff && !in_ignored; // RL8 RL12 RL13
		nxt_trip = cfg.enable && expired && !blocked; // RL17 RL19
		nxt_rec = nxt_trip && !trip_ff && cfg.recorder_trigger_enable; // RL20
		nxt_blk_out = '0;
		if (inst_ff && !out_released) nxt_blk_out[relay_select] = 1'b1; // RL10 RL11
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			inst_ff <= 1'b0;
			delay_ff <= '0;
			post_ff <= '0;
			trip_ff <= 1'b0;
			rec_ff <= 1'b0;
			blk_out_ff <= '0;
		end else begin
			inst_ff <= nxt_inst;
			delay_ff <= nxt_delay;
			post_ff <= nxt_post;
			trip_ff <= nxt_trip;
			rec_ff <= nxt_rec;
			blk_out_ff <= nxt_blk_out;
		end
	end

	// ****************************************
	// Inrush detection
	// ****************************************
	// A missed window waits for current below MIN_MEAS (0.02 In) before it may re-arm
	always_comb begin
		nxt_ir = ir_ff;
		nxt_ir_cnt = ir_cnt_ff;
		unique case (ir_ff)
			IR_IDLE: begin
				nxt_ir_cnt = '0;
				if (imax >= ocp_pkg::MIN_MEAS) nxt_ir = IR_WINDOW; // RL22
			end
			IR_WINDOW: begin
				if (imax < ocp_pkg::MIN_MEAS) nxt_ir = IR_IDLE;
				else if (cfg.inrush_doubling_enable && imax >= ocp_pkg::INRUSH_HI) begin
					nxt_ir = IR_DOUBLE; // RL15
					nxt_ir_cnt = '0;
				end else if (tick) begin
					nxt_ir_cnt = ir_cnt_ff + 18'h00001;
					if (ir_cnt_ff == 18'(ocp_pkg::INRUSH_WINDOW_MS - 1)) nxt_ir = IR_SPENT;
				end
			end
			IR_DOUBLE: begin
				if (imax < ocp_pkg::INRUSH_LO || ir_cnt_ff >= cfg.doubling_max_time ||
					!cfg.inrush_doubling_enable)
					nxt_ir = IR_SPENT; // RL16
				else if (tick) nxt_ir_cnt = ir_cnt_ff + 18'h00001;
			end
			IR_SPENT: begin
				if (imax < ocp_pkg::MIN_MEAS) nxt_ir = IR_IDLE;
			end
		endcase
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			ir_ff <= IR_IDLE;
			ir_cnt_ff <= '0;
		end else begin
			ir_ff <= nxt_ir;
			ir_cnt_ff <= nxt_ir_cnt;
		end
	end

	// Outputs
	assign trip = trip_ff;
	assign instantaneous = inst_ff;
	assign blocking_output = blk_out_ff;
	assign recorder_trigger = rec_ff;
	assign doubling_active = (ir_ff == IR_DOUBLE);

	// ****************************************
	// Assertions
	// ****************************************
	default clocking @(posedge clock); endclocking
	default disable iff (!resetn);

	property p_out_needs_inst;
		|blocking_output |-> $past(inst_ff);
	endproperty
	a_out_needs_inst: assert property (p_out_needs_inst) else $error("output without pick-up"); // RL10

	property p_out_release;
		out_released |=> blocking_output == '0;
	endproperty
	a_out_release: assert property (p_out_release) else $error("blocking output not released"); // RL11

	property p_trip_after_delay;
		$rose(trip) |-> $past(inst_ff) && $past(delay_ff >= cfg.trip_delay);
	endproperty
	a_trip_after_delay: assert property (p_trip_after_delay) else $error("early trip"); // RL17

	property p_disabled_quiet;
		!cfg.enable ##1 !cfg.enable |-> !trip && !instantaneous;
	endproperty
	a_disabled_quiet: assert property (p_disabled_quiet) else $error("disabled element active"); // RL19

	property p_block_off;
		cfg.block_logic_en && !cfg.block_input_release_option && in_sync_ff |=> !trip;
	endproperty
	a_block_off: assert property (p_block_off) else $error("trip while blocked"); // RL13

	property p_recorder;
		recorder_trigger |-> $rose(trip) && $past(cfg.recorder_trigger_enable);
	endproperty
	a_recorder: assert property (p_recorder) else $error("stray recorder trigger"); // RL20

	property p_double_level;
		cfg.enable && cfg.mode == ocp_pkg::MODE_NONDIR && dbl_now && !inst_ff &&
			imax <= {base_lvl, 1'b0} |=> !instantaneous;
	endproperty
	a_double_level: assert property (p_double_level) else $error("level not doubled"); // RL15

	property p_double_end;
		doubling_active && imax < ocp_pkg::INRUSH_LO |=> !doubling_active;
	endproperty
	a_double_end: assert property (p_double_end) else $error("doubling outlived current"); // RL16

	property p_dir_negative;
		cfg.enable && cfg.mode == ocp_pkg::MODE_DIRECT && !inst_ff && !(|ge_idx) |=> !inst_ff;
	endproperty
	a_dir_negative: assert property (p_dir_negative) else $error("directional false pick-up"); // RL2

endmodule

/* tb/field_model.sv */
`timescale 1ns/10ps
// ****************************************
// Measuring inputs and input contact
// ****************************************
module field_model (
	// Commanded field quantities
	input wire ocp_pkg::phase_meas_s [2:0] set_current,
	input wire logic [2:0][15:0] set_voltage,
	input wire logic contact_closed,
	// Quantities seen by the element
	output ocp_pkg::phase_meas_s [2:0] phase_current,
	output logic [2:0][15:0] phase_neutral_voltage,
	output logic blocking_input
);
	// Transformers follow the primary at once; a closed dry contact reads active
	assign phase_current = set_current;
	assign phase_neutral_voltage = set_voltage;
	assign blocking_input = contact_closed;
endmodule

/* tb/test_overcurrent_protection_element.sv */
`timescale 1ns/10ps
module test_overcurrent_protection_element;
	// ****************************************
	// Signals and instances
	// ****************************************
	logic clock = 1'b0;
	logic resetn = 1'b0;
	ocp_pkg::settings_s cfg;
	logic [1:0] relay_select;
	ocp_pkg::phase_meas_s [2:0] set_current = '0;
	logic [2:0][15:0] set_voltage = '0;
	logic contact_closed = 1'b0;
	ocp_pkg::phase_meas_s [2:0] phase_current;
	logic [2:0][15:0] phase_neutral_voltage;
	logic blocking_input, trip, instantaneous, recorder_trigger, doubling_active;
	logic [3:0] blocking_output;
	int miscompares = 0;
	int cmp_count = 0;
	int cycles = 0;

	// 10 MHz clock
	always #50 clock = ~clock;

	field_model far_side (
		.set_current(set_current),
		.set_voltage(set_voltage),
		.contact_closed(contact_closed),
		.phase_current(phase_current),
		.phase_neutral_voltage(phase_neutral_voltage),
		.blocking_input(blocking_input)
	);

	// Short tick so that millisecond timers stay cheap to simulate
	ocp_element #(.TICK_CYCLES(10), .RELAYS(4)) uut (
		.clock(clock),
		.resetn(resetn),
		.cfg(cfg),
		.relay_select(relay_select),
		.phase_current(phase_current),
		.phase_neutral_voltage(phase_neutral_voltage),
		.blocking_input(blocking_input),
		.trip(trip),
		.instantaneous(instantaneous),
		.blocking_output(blocking_output),
		.recorder_trigger(recorder_trigger),
		.doubling_active(doubling_active)
	);

	// Whole run needs under two thousand cycles; a hang is cut well beyond that
	always @(posedge clock) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			miscompares++;
			finish_test();
		end
	end

	// ****************************************
	// Shared tasks
	// ****************************************
	task automatic chk(input string what, input logic seen, input logic exp);
		cmp_count++;
		if (seen !== exp) begin
			miscompares++;
			$display("MISMATCH %s expected %b seen %b", what, exp, seen);
		end
	endtask

	task automatic finish_test();
		if (miscompares == 0 && cmp_count > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask

	task automatic cyc(input int n);
		repeat (n) @(negedge clock);
	endtask

	task automatic ph(input int p, input logic [15:0] m, input logic signed [15:0] r,
		input logic signed [15:0] i);
		set_current[p] = '{mag: m, re: r, im: i};
	endtask

	// Trip rises on a tick boundary, so wait for it under a bound
	task automatic wait_trip(input int limit);
		int n;
		for (n = 0; n < limit && trip !== 1'b1; n++) begin
			cyc(1);
		end
	endtask

	// Reset between scenarios clears timers and re-arms inrush detection
	task automatic idle();
		set_current = '0;
		set_voltage = {3{16'h03e8}};
		contact_closed = 1'b0;
		resetn = 1'b0;
		cyc(2);
		resetn = 1'b1;
		cyc(2);
	endtask

	// Level 1.0 In, delay 3 ms, release 2 ms, doubling limit 5 ms
	task automatic base();
		cfg = '0;
		cfg.enable = 1'b1;
		cfg.mode = ocp_pkg::MODE_NONDIR;
		cfg.pickup_level = 16'h03e8;
		cfg.cos_ref = 16'sh4000;
		cfg.trip_delay = 18'h00003;
		cfg.block_output_release_time = 18'h00002;
		cfg.doubling_max_time = 18'h00005;
		cfg.rated_voltage = 16'h06c4;
		relay_select = 2'h2;
	endtask

	// ****************************************
	// Scenarios
	// ****************************************
	task automatic s_trip();
		base();
		cfg.recorder_trigger_enable = 1'b1;
		ph(1, 16'h03e8, 16'sh03e8, 16'sh0000);
		cyc(3);
		chk("inst at level", instantaneous, 1'b0);
		ph(1, 16'h04b0, 16'sh04b0, 16'sh0000);
		cyc(1);
		chk("inst", instantaneous, 1'b1);
		cyc(1);
		chk("blocking relay", blocking_output === 4'h4, 1'b1);
		cyc(13);
		chk("trip early", trip, 1'b0);
		wait_trip(30);
		chk("trip", trip, 1'b1);
		chk("rec", recorder_trigger, 1'b1);
		chk("relay held", blocking_output === 4'h4, 1'b1);
		cyc(1);
		chk("rec pulse", recorder_trigger, 1'b0);
		cyc(25);
		chk("relay released", blocking_output === 4'h0, 1'b1);
		chk("inst kept", instantaneous, 1'b1);
		ph(1, 16'h03c0, 16'sh03c0, 16'sh0000);
		cyc(2);
		chk("hold 96", instantaneous, 1'b1);
		ph(1, 16'h03ac, 16'sh03ac, 16'sh0000);
		cyc(2);
		chk("drop 94", instantaneous, 1'b0);
		idle();
	endtask

	// Reference 0, 90 and 180 degrees against in-line, square and opposed currents
	task automatic s_dir();
		logic signed [15:0] cs [6] = '{16'sh4000, 16'sh4000, 16'sh4000, 16'sh0000,
			-16'sh4000, 16'sh4000};
		logic signed [15:0] sn [6] = '{0, 0, 0, 16'sh4000, 0, 0};
		logic signed [15:0] rv [6] = '{16'sh03e8, -16'sh05dc, 0, 0, -16'sh05dc, 16'sh03de};
		logic signed [15:0] iv [6] = '{0, 0, 16'sh05dc, 16'sh05dc, 0, 0};
		logic [15:0] mg [6] = '{16'h03e8, 16'h05dc, 16'h05dc, 16'h05dc, 16'h05dc, 16'h03de};
		logic ex [6] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
		base();
		cfg.mode = ocp_pkg::MODE_DIRECT;
		set_voltage = {3{16'h0014}};
		for (int i = 0; i < 6; i++) begin
			cfg.cos_ref = cs[i];
			cfg.sin_ref = sn[i];
			ph(2, mg[i], rv[i], iv[i]);
			cyc(3);
			chk("dir pickup", instantaneous, ex[i]);
			ph(2, 16'h0000, 16'sh0000, 16'sh0000);
			cyc(2);
		end
		idle();
	endtask

	// Largest phase decides the direction; lost voltage stops operation
	task automatic s_sup();
		base();
		cfg.mode = ocp_pkg::MODE_SUPERV;
		ph(0, 16'h04b0, -16'sh04b0, 16'sh0000);
		ph(1, 16'h044c, 16'sh044c, 16'sh0000);
		cyc(3);
		chk("sup reverse", instantaneous, 1'b0);
		ph(0, 16'h04b0, 16'sh04b0, 16'sh0000);
		cyc(3);
		chk("sup forward", instantaneous, 1'b1);
		set_voltage = '0;
		cyc(80);
		chk("sup no volt", instantaneous, 1'b0);
		idle();
	endtask

	task automatic s_block();
		base();
		cfg.block_logic_en = 1'b1;
		contact_closed = 1'b1;
		ph(0, 16'h04b0, 16'sh04b0, 16'sh0000);
		cyc(150);
		chk("blocked", trip, 1'b0);
		chk("inst free", instantaneous, 1'b1);
		contact_closed = 1'b0;
		cyc(4);
		chk("unblocked", trip, 1'b1);
		idle();
		base();
		cfg.block_logic_en = 1'b1;
		cfg.block_input_release_option = 1'b1;
		contact_closed = 1'b1;
		ph(0, 16'h04b0, 16'sh04b0, 16'sh0000);
		cyc(40);
		chk("blocked 2x", trip, 1'b0);
		wait_trip(50);
		chk("block ignored", trip, 1'b1);
		chk("no rec", recorder_trigger, 1'b0);
		idle();
		base();
		contact_closed = 1'b1;
		ph(0, 16'h04b0, 16'sh04b0, 16'sh0000);
		wait_trip(40);
		chk("logic off", trip, 1'b1);
		idle();
	endtask

	task automatic s_off();
		base();
		cfg.enable = 1'b0;
		ph(0, 16'h05dc, 16'sh05dc, 16'sh0000);
		cyc(60);
		chk("off inst", instantaneous, 1'b0);
		chk("off trip", trip, 1'b0);
		chk("off relay", blocking_output === 4'h0, 1'b1);
		idle();
	endtask

	// Fast rise, drop below 1.25 In, time limit, then a rise too slow
	task automatic s_inrush();
		for (int k = 0; k < 3; k++) begin
			base();
			cfg.inrush_doubling_enable = 1'b1;
			ph(0, 16'h001e, 16'sh001e, 16'sh0000);
			cyc(k == 2 ? 700 : 3);
			ph(0, 16'h0640, 16'sh0640, 16'sh0000);
			cyc(1);
			chk("doubled", doubling_active, k != 2);
			chk("pick only when slow", instantaneous, k == 2);
			if (k == 0) begin
				ph(0, 16'h0514, 16'sh0514, 16'sh0000);
				cyc(2);
				chk("still doubled", doubling_active, 1'b1);
				ph(0, 16'h04b0, 16'sh04b0, 16'sh0000);
				cyc(4);
				chk("undoubled", doubling_active, 1'b0);
				chk("level back", instantaneous, 1'b1);
			end
			if (k == 1) begin
				cyc(70);
				chk("max time", doubling_active, 1'b0);
				chk("max level", instantaneous, 1'b1);
			end
			idle();
		end
	endtask

	// Smallest phase voltage at 0.5, 0.1 and 1.0 of rated
	task automatic s_rst();
		logic [15:0] vt [6] = '{16'h01f4, 16'h01f4, 16'h0064, 16'h0064, 16'h03e8, 16'h03e8};
		logic [15:0] ct [6] = '{16'h028a, 16'h0226, 16'h00fa, 16'h0096, 16'h03de, 16'h03f2};
		logic ex [6] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1};
		base();
		cfg.restraint_en = 1'b1;
		for (int i = 0; i < 6; i++) begin
			set_voltage = {16'h03e8, vt[i], 16'h03e8};
			cyc(80);
			ph(0, ct[i], 16'sh0000, 16'sh0000);
			cyc(3);
			chk("restrained", instantaneous, ex[i]);
			ph(0, 16'h0000, 16'sh0000, 16'sh0000);
			cyc(2);
		end
		idle();
	endtask

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		base();
		set_voltage = {3{16'h03e8}};
		cyc(10);
		resetn = 1'b1;
		cyc(2);
		chk("reset trip", trip, 1'b0);
		s_trip();
		s_dir();
		s_sup();
		s_block();
		s_off();
		s_inrush();
		s_rst();
		finish_test();
	end
endmodule
